// ==== design/gpm_gpio_map.sv ====
// Multipurpose pin function map: pin edges trigger device actions, or the pin shows a status
// Assumes a classic Wishbone master and an NVM image valid from reset release
//
// Contract
// RQ1 - Input enable bit makes pin an input
// RQ2 - Output enable bit drives the pin
// RQ3 - Channel functions act on selected channels only
// RQ4 - Pin level at power-on runs its command
// RQ5 - Default configuration maps pin to nothing
// RQ6 - Mapped function ignores its software trigger
// RQ7 - External driver resets with a low pulse
// RQ8 - Pin triggers obey software trigger restrictions
// RQ9 - Volatile reset mapping lost; NVM mapping persists
// RQ10 - Fall triggers fault dump, protect, clear
// RQ11 - Voltage output down on fall, up on rise
// RQ12 - Current, waveform, margin follow pin edges
// RQ13 - Low pulse resets only with NVM mapping
// RQ14 - Edges allow or block NVM, register writes
// RQ15 - Sync update on fall for synced channels
// RQ16 - Status source code selects output level
// RQ17 - Unlisted function codes do nothing
// RQ18 - Synchronise pin; one trigger per edge
`include "gpm_map.svh"
`timescale 1ns/1ps
module gpm_gpio_map #(
   parameter logic [3:0] UNLOCK_KEY = 4'hA
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Multipurpose pin
   input wire logic pin_i,
   output logic pin_o,
   output logic pin_oe_n_o,
   // NVM image and status sources
   input wire logic [15:0] nvm_gpio_cfg_i,
   input wire logic nvm_busy_i,
   input wire logic [1:0] dac_busy_i,
   input wire logic [1:0] win_cmp_i,
   // Global actions
   output logic fault_dump_o,
   output logic protect_o,
   output logic output_clear_o,
   output logic device_reset_o,
   output logic nvm_prog_block_o,
   output logic reg_lock_o,
   // Channel actions
   output logic [1:0] iout_pdn_o,
   output logic [1:0] vout_pdn_o,
   output logic [3:0] vout_pdn_option_o,
   output logic [1:0] func_run_o,
   output logic [1:0] margin_low_o,
   output logic [1:0] margin_high_o,
   output logic [1:0] sync_update_o
);

   localparam int NCH = 2;

   function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] off);
      reg_hit = (adr[7:2] == off[7:2]);
   endfunction

   function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [15:0] nw,
                                              input logic [1:0] sel);
      lane_merge = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
   endfunction

   function automatic logic mapped(input logic mode, input logic [3:0] code, input logic [3:0] f);
      mapped = mode & (code == f);
   endfunction

   logic [15:0] gpio_cfg;
   logic [15:0] ch_cfg;
   gpm_pkg::gpm_init_t init_st;
   logic [2:0] settle_cnt;
   logic pin_lvl, pin_rise, pin_fall;
   logic low_armed;
   logic [3:0] fn;
   logic [3:0] src;
   logic [NCH-1:0] chsel;
   logic [NCH-1:0] sync_cfg;
   logic in_mode;
   logic ev_fall, ev_rise, lvl_fall, lvl_rise;
   logic bus_wr;
   logic [15:0] wlane;
   logic [15:0] sw_raw;
   logic [15:0] sw_ok;
   logic key_hit;
   logic nvm_reset_ok;
   logic src_lvl;
   logic [15:0] rdata;
   logic map_fault, map_protect, map_clear, map_iout, map_vout, map_sync;
   logic map_func, map_margin, map_reset, map_nvmlk, map_reglk;
   wire logic [NCH-1:0] next_iout;
   wire logic [NCH-1:0] next_vout;
   wire logic [NCH-1:0] next_run;
   wire logic [NCH-1:0] next_mlo;
   wire logic [NCH-1:0] next_mhi;
   wire logic [NCH-1:0] next_sync;

   gpm_pin_sync u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(pin_i),
      .level_o(pin_lvl),
      .rise_o(pin_rise),
      .fall_o(pin_fall)
   );

   assign fn = gpio_cfg[`GPM_FN_MSB:`GPM_FN_LSB];
   assign src = gpio_cfg[`GPM_SRC_MSB:`GPM_SRC_LSB];
   assign chsel = gpio_cfg[`GPM_CHSEL_LSB+NCH-1:`GPM_CHSEL_LSB];
   assign sync_cfg = ch_cfg[`GPM_SYNC_LSB+NCH-1:`GPM_SYNC_LSB];
   assign vout_pdn_option_o = ch_cfg[`GPM_PDN_OPT_MSB:`GPM_PDN_OPT_LSB];
   // Output mode wins when both enables are set
   assign in_mode = gpio_cfg[`GPM_IN_EN_BIT] & ~gpio_cfg[`GPM_OUT_EN_BIT]; // see RQ1
   // Codes outside the enum never match, so they trigger nothing
   assign map_fault = mapped(in_mode, fn, gpm_pkg::FN_FAULT); // see RQ17
   assign map_protect = mapped(in_mode, fn, gpm_pkg::FN_PROTECT);
   assign map_clear = mapped(in_mode, fn, gpm_pkg::FN_CLEAR);
   assign map_iout = mapped(in_mode, fn, gpm_pkg::FN_IOUT);
   assign map_vout = mapped(in_mode, fn, gpm_pkg::FN_VOUT);
   assign map_sync = mapped(in_mode, fn, gpm_pkg::FN_SYNC);
   assign map_func = mapped(in_mode, fn, gpm_pkg::FN_FUNC);
   assign map_margin = mapped(in_mode, fn, gpm_pkg::FN_MARGIN);
   assign map_reset = mapped(in_mode, fn, gpm_pkg::FN_RESET);
   assign map_nvmlk = mapped(in_mode, fn, gpm_pkg::FN_NVM_LOCK);
   assign map_reglk = mapped(in_mode, fn, gpm_pkg::FN_REG_LOCK);

   // Edges count only once the synchroniser has settled
   assign ev_fall = in_mode & (init_st == gpm_pkg::GPM_RUN) & pin_fall; // see RQ18
   assign ev_rise = in_mode & (init_st == gpm_pkg::GPM_RUN) & pin_rise;
   // Level-pair functions also act once on the power-on level
   assign lvl_fall = ev_fall | (in_mode & (init_st == gpm_pkg::GPM_APPLY) & ~pin_lvl); // see RQ4
   assign lvl_rise = ev_rise | (in_mode & (init_st == gpm_pkg::GPM_APPLY) & pin_lvl);

   // Reset via pin needs the same mapping held in the NVM image
   assign nvm_reset_ok = nvm_gpio_cfg_i[`GPM_IN_EN_BIT] & ~nvm_gpio_cfg_i[`GPM_OUT_EN_BIT]
                         & (nvm_gpio_cfg_i[`GPM_FN_MSB:`GPM_FN_LSB] == gpm_pkg::FN_RESET); // see RQ9

   // Write commits at the edge where the master sees ack
   assign bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
   assign wlane = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00, wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00};
   assign sw_raw = (bus_wr & reg_hit(wb_adr_i, `GPM_OFF_SW_TRIG)) ? wlane : 16'h0000;
   // Locked: only the key and the reset field pass
   assign sw_ok = reg_lock_o ? (sw_raw & `GPM_TRIG_LOCK_MASK) : sw_raw; // see RQ14
   assign key_hit = wb_sel_i[1] & (sw_raw[`GPM_TRIG_KEY_MSB:`GPM_TRIG_KEY_LSB] == UNLOCK_KEY);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         init_st <= gpm_pkg::GPM_LOAD;
         settle_cnt <= 3'h0;
      end else begin
         case (init_st)
            gpm_pkg::GPM_LOAD: begin
               init_st <= gpm_pkg::GPM_SETTLE;
            end
            gpm_pkg::GPM_SETTLE: begin
               settle_cnt <= settle_cnt + 3'h1;
               if (settle_cnt == `GPM_SETTLE_CYC) begin
                  init_st <= gpm_pkg::GPM_APPLY;
               end
            end
            gpm_pkg::GPM_APPLY: begin
               init_st <= gpm_pkg::GPM_RUN;
            end
            gpm_pkg::GPM_RUN: begin
               init_st <= gpm_pkg::GPM_RUN;
            end
            default: begin
               init_st <= gpm_pkg::GPM_LOAD;
            end
         endcase
      end
   end

   // Volatile copy reloads from the NVM image after every reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gpio_cfg <= `GPM_GPIO_CFG_RST; // see RQ5
         ch_cfg <= `GPM_CH_CFG_RST;
      end else begin
         if (init_st == gpm_pkg::GPM_LOAD) begin
            gpio_cfg <= nvm_gpio_cfg_i; // see RQ9
         end else if (bus_wr & ~reg_lock_o & reg_hit(wb_adr_i, `GPM_OFF_GPIO_CFG)) begin
            gpio_cfg <= lane_merge(gpio_cfg, wb_dat_i[15:0], wb_sel_i[1:0]);
         end
         if (bus_wr & ~reg_lock_o & reg_hit(wb_adr_i, `GPM_OFF_CH_CFG)) begin
            ch_cfg <= lane_merge(ch_cfg, wb_dat_i[15:0], wb_sel_i[1:0]);
         end
      end
   end

   always_comb begin
      rdata = 16'h0000;
      if (reg_hit(wb_adr_i, `GPM_OFF_GPIO_CFG)) begin
         rdata = gpio_cfg;
      end else if (reg_hit(wb_adr_i, `GPM_OFF_CH_CFG)) begin
         rdata = ch_cfg;
      end else if (reg_hit(wb_adr_i, `GPM_OFF_STATUS)) begin
         rdata = {6'h00, func_run_o, vout_pdn_o, iout_pdn_o, init_st == gpm_pkg::GPM_RUN,
                  nvm_prog_block_o, reg_lock_o, pin_lvl};
      end
   end

   // Trigger word and unmapped offsets read as zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
         if (wb_cyc_i & wb_stb_i & ~wb_ack_o) begin
            wb_dat_o <= {16'h0000, rdata};
         end
      end
   end

   always_comb begin
      case (src)
         gpm_pkg::SRC_NVM_BUSY: src_lvl = nvm_busy_i; // see RQ16
         gpm_pkg::SRC_BUSY1: src_lvl = dac_busy_i[1];
         gpm_pkg::SRC_BUSY0: src_lvl = dac_busy_i[0];
         gpm_pkg::SRC_WIN1: src_lvl = win_cmp_i[1];
         gpm_pkg::SRC_WIN0: src_lvl = win_cmp_i[0];
         default: src_lvl = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_o <= 1'b0;
         pin_oe_n_o <= 1'b1;
      end else begin
         pin_o <= gpio_cfg[`GPM_OUT_EN_BIT] & src_lvl;
         pin_oe_n_o <= ~gpio_cfg[`GPM_OUT_EN_BIT]; // see RQ2
      end
   end

   // Pulse events fire only on real edges, never on the power-on level
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fault_dump_o <= 1'b0;
         protect_o <= 1'b0;
         output_clear_o <= 1'b0;
         device_reset_o <= 1'b0;
         low_armed <= 1'b0;
      end else begin
         fault_dump_o <= (map_fault & ev_fall) | (sw_ok[`GPM_TRIG_FAULT] & ~map_fault); // see RQ10, RQ6
         protect_o <= (map_protect & ev_fall) | (sw_ok[`GPM_TRIG_PROTECT] & ~map_protect);
         output_clear_o <= (map_clear & ev_fall) | (sw_ok[`GPM_TRIG_CLEAR] & ~map_clear);
         // Rising edge fires only after a fall was seen
         device_reset_o <= (map_reset & nvm_reset_ok & ev_rise & low_armed)
                           | (sw_ok[`GPM_TRIG_RESET] & ~map_reset); // see RQ13, RQ7
         if (ev_fall) begin
            low_armed <= map_reset;
         end else if (ev_rise | ~map_reset) begin // Stale arm from an old mapping never fires
            low_armed <= 1'b0;
         end
      end
   end

   // Hardware set wins over the key clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reg_lock_o <= 1'b0;
         nvm_prog_block_o <= 1'b0;
      end else begin
         if (map_reglk & lvl_rise) begin
            reg_lock_o <= 1'b1; // see RQ14
         end else if ((map_reglk & lvl_fall) | key_hit) begin
            reg_lock_o <= 1'b0;
         end
         if (map_nvmlk & lvl_rise) begin
            nvm_prog_block_o <= 1'b1;
         end else if (map_nvmlk & lvl_fall) begin
            nvm_prog_block_o <= 1'b0;
         end
      end
   end

   for (genvar c = 0; c < NCH; c++) begin : g_ch
      assign next_iout[c] = (map_iout & chsel[c] & lvl_fall) ? 1'b1 :
                            (map_iout & chsel[c] & lvl_rise) ? 1'b0 : iout_pdn_o[c]; // see RQ3, RQ12
      assign next_vout[c] = (map_vout & chsel[c] & lvl_fall) ? 1'b1 :
                            (map_vout & chsel[c] & lvl_rise) ? 1'b0 : vout_pdn_o[c]; // see RQ11
      assign next_run[c] = (map_func & chsel[c] & lvl_fall) ? 1'b0 :
                           (map_func & chsel[c] & lvl_rise) ? 1'b1 :
                           (sw_ok[`GPM_TRIG_START_LSB+c] & ~map_func) ? 1'b1 : func_run_o[c];
      assign next_mlo[c] = (map_margin & chsel[c] & ev_fall) | (sw_ok[`GPM_TRIG_MLO_LSB+c] & ~map_margin);
      assign next_mhi[c] = (map_margin & chsel[c] & ev_rise) | (sw_ok[`GPM_TRIG_MHI_LSB+c] & ~map_margin);
      // Same sync gating for pin and software
      assign next_sync[c] = sync_cfg[c] & ((map_sync & chsel[c] & ev_fall)
                            | (sw_ok[`GPM_TRIG_SYNC] & ~map_sync)); // see RQ15, RQ8
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         iout_pdn_o <= 2'h0;
         vout_pdn_o <= 2'h0;
         func_run_o <= 2'h0;
         margin_low_o <= 2'h0;
         margin_high_o <= 2'h0;
         sync_update_o <= 2'h0;
      end else begin
         iout_pdn_o <= next_iout;
         vout_pdn_o <= next_vout;
         func_run_o <= next_run;
         margin_low_o <= next_mlo;
         margin_high_o <= next_mhi;
         sync_update_o <= next_sync;
      end
   end

   AST_OE_IDLE: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ2
      !gpio_cfg[`GPM_OUT_EN_BIT] |=> pin_oe_n_o && !pin_o) else $error("pin driven while output disabled");
   AST_NO_INPUT: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ1
      (!in_mode && sw_raw == 16'h0000) |=> !fault_dump_o && !protect_o && !output_clear_o)
      else $error("pin action without input mode");
   AST_CH_SEL: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ3
      (map_iout && !chsel[0]) |=> $stable(iout_pdn_o[0])) else $error("unselected channel changed");
   AST_INIT_LVL: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ4
      (init_st == gpm_pkg::GPM_APPLY && map_vout && chsel[0] && !pin_lvl) |=> vout_pdn_o[0])
      else $error("power-on level not applied");
   AST_RST_IDLE: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ5
      $past(rst_i) |-> !fault_dump_o && !device_reset_o && pin_oe_n_o && gpio_cfg == `GPM_GPIO_CFG_RST)
      else $error("action right after reset");
   AST_SW_MASK: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ6
      (map_fault && sw_ok[`GPM_TRIG_FAULT] && !ev_fall) |=> !fault_dump_o) else $error("software trigger not masked");
   AST_NVM_LOAD: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ9
      init_st == gpm_pkg::GPM_LOAD |=> gpio_cfg == $past(nvm_gpio_cfg_i)) else $error("NVM image not loaded");
   AST_RISE_NOP: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ10
      (map_fault && ev_rise && !sw_raw[`GPM_TRIG_FAULT]) |=> !fault_dump_o) else $error("rising edge fired fault");
   AST_FUNC_START: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ12
      (map_func && chsel[1] && ev_rise) |=> func_run_o[1]) else $error("waveform did not start");
   AST_RST_PULSE: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ13
      (map_reset && !low_armed && !sw_ok[`GPM_TRIG_RESET]) |=> !device_reset_o) else $error("reset without low pulse");
   AST_LOCK_WR: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ14
      (init_st == gpm_pkg::GPM_RUN && reg_lock_o && bus_wr) |=> $stable(gpio_cfg) && $stable(ch_cfg))
      else $error("write passed the lock");
   AST_SYNC_CFG: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ15
      sync_update_o[0] |-> $past(sync_cfg[0])) else $error("sync on unsynced channel");
   AST_SRC_NVM: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ16
      (gpio_cfg[`GPM_OUT_EN_BIT] && src == gpm_pkg::SRC_NVM_BUSY) |=> pin_o == $past(nvm_busy_i))
      else $error("status pin wrong");
   AST_UNLISTED: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ17
      (in_mode && fn == 4'h6) |=> $stable(iout_pdn_o) && $stable(vout_pdn_o) && !low_armed)
      else $error("unlisted code acted");
   AST_ONE_SHOT: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ18
      fault_dump_o |=> !fault_dump_o) else $error("double trigger");

   COV_PIN_FAULT: cover property (@(posedge clk_i) disable iff (rst_i) map_fault && ev_fall ##1 fault_dump_o);
   COV_PIN_RESET: cover property (@(posedge clk_i) disable iff (rst_i) map_reset && ev_rise ##1 device_reset_o);
   COV_OUT_DRIVE: cover property (@(posedge clk_i) disable iff (rst_i) !pin_oe_n_o && pin_o);
   COV_LOCK: cover property (@(posedge clk_i) disable iff (rst_i) $rose(reg_lock_o));

endmodule

// ==== design/gpm_map.svh ====
// Register offsets, field positions, reset values and timing counts of the pin map block
// Included by bare name; holds definitions only
`ifndef GPM_MAP_SVH
`define GPM_MAP_SVH

`define GPM_OFF_GPIO_CFG 8'h00
`define GPM_OFF_CH_CFG 8'h04
`define GPM_OFF_SW_TRIG 8'h08
`define GPM_OFF_STATUS 8'h0C

`define GPM_GPIO_CFG_RST 16'h0000
`define GPM_CH_CFG_RST 16'h0000

// Pin configuration word
`define GPM_IN_EN_BIT 0
`define GPM_FN_LSB 1
`define GPM_FN_MSB 4
`define GPM_CHSEL_LSB 5
`define GPM_SRC_LSB 9
`define GPM_SRC_MSB 12
`define GPM_OUT_EN_BIT 13

// Channel configuration word
`define GPM_SYNC_LSB 0
`define GPM_PDN_OPT_LSB 2
`define GPM_PDN_OPT_MSB 5

// Software trigger word
`define GPM_TRIG_FAULT 0
`define GPM_TRIG_PROTECT 1
`define GPM_TRIG_CLEAR 2
`define GPM_TRIG_SYNC 3
`define GPM_TRIG_RESET 4
`define GPM_TRIG_START_LSB 5
`define GPM_TRIG_MLO_LSB 7
`define GPM_TRIG_MHI_LSB 9
`define GPM_TRIG_KEY_LSB 12
`define GPM_TRIG_KEY_MSB 15
`define GPM_TRIG_LOCK_MASK 16'hF010

// Last settle count before the pin level is trusted, 7 cycles after load
`define GPM_SETTLE_CYC 3'h6

`endif

// ==== design/gpm_pkg.sv ====
// Types shared by the pin map block
// Assumes nothing beyond a SystemVerilog compiler
package gpm_pkg;

   typedef enum logic [1:0] {
      GPM_LOAD = 2'h0,
      GPM_SETTLE = 2'h1,
      GPM_APPLY = 2'h3,
      GPM_RUN = 2'h2
   } gpm_init_t;

   typedef enum logic [3:0] {
      FN_FAULT = 4'h2,
      FN_IOUT = 4'h3,
      FN_VOUT = 4'h4,
      FN_PROTECT = 4'h5,
      FN_CLEAR = 4'h7,
      FN_SYNC = 4'h8,
      FN_FUNC = 4'h9,
      FN_MARGIN = 4'hA,
      FN_RESET = 4'hB,
      FN_NVM_LOCK = 4'hC,
      FN_REG_LOCK = 4'hD
   } gpm_fn_t;

   typedef enum logic [3:0] {
      SRC_NVM_BUSY = 4'h1,
      SRC_BUSY1 = 4'h4,
      SRC_BUSY0 = 4'h7,
      SRC_WIN1 = 4'h8,
      SRC_WIN0 = 4'hB
   } gpm_src_t;

endpackage

// ==== design/gpm_pin_sync.sv ====
// Two-stage synchroniser and edge detector for the multipurpose pin
// Assumes the pin is asynchronous to clk_i
`timescale 1ns/1ps
module gpm_pin_sync (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Pin
   input wire logic pin_i,
   // Synchronised level and one-cycle edges
   output logic level_o,
   output logic rise_o,
   output logic fall_o
);

   logic meta;
   logic stage;

   // First stage is read only by the second
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta <= 1'b0;
         stage <= 1'b0;
      end else begin
         meta <= pin_i;
         stage <= meta;
      end
   end

   // One pulse per edge, since level_o is the previous stage value
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level_o <= 1'b0;
         rise_o <= 1'b0;
         fall_o <= 1'b0;
      end else begin
         level_o <= stage;
         rise_o <= stage & ~level_o;
         fall_o <= ~stage & level_o;
      end
   end

endmodule

// ==== bench/gpm_pin_driver.sv ====
// Board-side driver of the multipurpose pin
// Assumes the bench calls its tasks right after a rising clock edge
`timescale 1ns/1ps
module gpm_pin_driver (
   // Clock
   input wire logic clk_i,
   // Pin level seen by the block
   output logic pin_o
);
   // Strapped high when idle, like a pull-up
   initial pin_o = 1'b1;

   task automatic set_level(input logic lvl);
      @(posedge clk_i);
      pin_o <= lvl;
   endtask

   // Held low several cycles so the synchroniser cannot miss it
   task automatic low_pulse();
      set_level(1'b0);
      repeat (4) @(posedge clk_i);
      pin_o <= 1'b1;
   endtask
endmodule

// ==== bench/test_gpm_gpio_map.sv ====
// Self-checking bench for the pin function map
// Assumes the pin driver model and a single 10 MHz clock
`timescale 1ns/1ps
`include "gpm_map.svh"
module test_gpm_gpio_map;
   logic clk_i, rst_i, cyc, stb, we, pin, ack, pin_o, oe_n, nvm_busy;
   logic fault, prot, clr, devrst, nvmblk, rlock;
   logic [7:0] adr;
   logic [31:0] dat_w, dat_r, rd;
   logic [15:0] nvm_cfg;
   logic [1:0] dac_busy, win, iout, vout, frun, mlo, mhi, syn;
   logic [3:0] pdn_opt, sel;
   logic [3:0] pc [3] = '{4'h2, 4'h5, 4'h7};
   logic [3:0] lc [5] = '{4'h3, 4'h4, 4'h9, 4'hC, 4'hD};
   logic [3:0] sc [5] = '{4'h1, 4'h4, 4'h7, 4'h8, 4'hB};
   integer cnt [7] = '{default: 0};
   int error_cnt = 0;
   int samples_checked = 0;
   integer b;

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   gpm_pin_driver u_pin (.clk_i(clk_i), .pin_o(pin));

   gpm_gpio_map u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
      .pin_i(pin), .pin_o(pin_o), .pin_oe_n_o(oe_n), .nvm_gpio_cfg_i(nvm_cfg), .nvm_busy_i(nvm_busy),
      .dac_busy_i(dac_busy), .win_cmp_i(win), .fault_dump_o(fault), .protect_o(prot),
      .output_clear_o(clr), .device_reset_o(devrst), .nvm_prog_block_o(nvmblk), .reg_lock_o(rlock),
      .iout_pdn_o(iout), .vout_pdn_o(vout), .vout_pdn_option_o(pdn_opt), .func_run_o(frun),
      .margin_low_o(mlo), .margin_high_o(mhi), .sync_update_o(syn));

   // Counted on the falling edge, where pulses are settled
   always @(negedge clk_i) begin
      cnt[0] += fault;
      cnt[1] += prot;
      cnt[2] += clr;
      cnt[3] += devrst;
      cnt[4] += mlo;
      cnt[5] += mhi;
      cnt[6] += syn;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Classic cycle; caller enters just after a rising edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [3:0] s = 4'h3);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= s;
      adr <= a;
      dat_w <= {16'h0000, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) begin
         error_cnt++;
         final_report();
      end else begin
         rd = dat_r;
         cyc <= 1'b0;
         stb <= 1'b0;
         @(posedge clk_i);
      end
   endtask

   function automatic logic [15:0] cfg(input logic [3:0] f, input logic [1:0] c);
      cfg = {9'h000, c, f, 1'b1};
   endfunction

   function automatic logic [1:0] lvl(input logic [3:0] c);
      case (c)
         4'h3: lvl = iout;
         4'h4: lvl = vout;
         4'h9: lvl = frun;
         4'hC: lvl = {1'b0, nvmblk};
         default: lvl = {1'b0, rlock};
      endcase
   endfunction

   task automatic do_reset();
      int n;
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      n = 0;
      do begin
         wb(1'b0, `GPM_OFF_STATUS, 16'h0000);
         n++;
      end while (rd[3] !== 1'b1 && n < 20);
      if (rd[3] !== 1'b1) begin
         error_cnt++;
         final_report();
      end
   endtask

   task automatic edge_chk(input logic l, input int k, input int exp);
      b = cnt[k];
      u_pin.set_level(l);
      repeat (8) @(posedge clk_i);
      check(cnt[k] - b, exp);
   endtask

   initial begin
      {rst_i, cyc, stb, we, sel, adr, dat_w, nvm_cfg, nvm_busy, dac_busy, win} = 0;
      do_reset();
      wb(1'b0, `GPM_OFF_GPIO_CFG, 16'h0000);
      check(rd, 32'h0000_0000);
      check(oe_n, 1'b1);
      wb(1'b0, 8'h10, 16'h0000);
      check(rd, 32'h0000_0000);
      // Upper lane masked off, so the output enable must not land
      wb(1'b1, `GPM_OFF_GPIO_CFG, 16'h2004, 4'h1);
      edge_chk(1'b0, 0, 0);
      edge_chk(1'b1, 0, 0);
      check(oe_n, 1'b1);
      $display("defaults done");
      for (int i = 0; i < 3; i++) begin
         wb(1'b1, `GPM_OFF_GPIO_CFG, cfg(pc[i], 2'h0));
         edge_chk(1'b0, i, 1);
         edge_chk(1'b1, i, 0);
      end
      wb(1'b1, `GPM_OFF_GPIO_CFG, cfg(4'hA, 2'h2));
      edge_chk(1'b0, 4, 2);
      edge_chk(1'b1, 5, 2);
      wb(1'b1, `GPM_OFF_CH_CFG, 16'h0001);
      wb(1'b1, `GPM_OFF_GPIO_CFG, cfg(4'h8, 2'h3));
      edge_chk(1'b0, 6, 1);
      edge_chk(1'b1, 6, 0);
      $display("pulse codes done");
      for (int i = 0; i < 5; i++) begin
         wb(1'b1, `GPM_OFF_GPIO_CFG, cfg(lc[i], 2'h2));
         u_pin.set_level(1'b0);
         repeat (8) @(posedge clk_i);
         check(lvl(lc[i]), (lc[i] < 4'h5) ? 2'h2 : 2'h0);
         u_pin.set_level(1'b1);
         repeat (8) @(posedge clk_i);
         check(lvl(lc[i]), (lc[i] < 4'h5) ? 2'h0 : ((lc[i] == 4'h9) ? 2'h2 : 2'h1));
      end
      // Register lock still set by the last rise
      wb(1'b1, `GPM_OFF_CH_CFG, 16'h003C);
      wb(1'b0, `GPM_OFF_CH_CFG, 16'h0000);
      check(rd, 32'h0000_0001);
      u_pin.set_level(1'b0);
      repeat (8) @(posedge clk_i);
      wb(1'b1, `GPM_OFF_CH_CFG, 16'h003C);
      wb(1'b0, `GPM_OFF_CH_CFG, 16'h0000);
      check(rd, 32'h0000_003C);
      check(pdn_opt, 4'hF);
      u_pin.set_level(1'b1);
      repeat (8) @(posedge clk_i);
      check(rlock, 1'b1);
      // Reset field still passes the lock; the key clears it
      b = cnt[3];
      wb(1'b1, `GPM_OFF_SW_TRIG, 16'h0011);
      check(cnt[3] - b, 1);
      wb(1'b1, `GPM_OFF_SW_TRIG, 16'hA000);
      check(rlock, 1'b0);
      $display("level codes done");
      wb(1'b1, `GPM_OFF_GPIO_CFG, cfg(4'h2, 2'h0));
      b = cnt[0];
      wb(1'b1, `GPM_OFF_SW_TRIG, 16'h0001);
      repeat (8) @(posedge clk_i);
      check(cnt[0] - b, 0);
      wb(1'b1, `GPM_OFF_GPIO_CFG, cfg(4'h6, 2'h3));
      b = cnt[0];
      wb(1'b1, `GPM_OFF_SW_TRIG, 16'h0001);
      repeat (8) @(posedge clk_i);
      check(cnt[0] - b, 1);
      edge_chk(1'b0, 0, 0);
      edge_chk(1'b1, 1, 0);
      $display("software trigger done");
      for (int i = 0; i < 5; i++) begin
         {nvm_busy, dac_busy, win} <= 5'h10 >> i;
         wb(1'b1, `GPM_OFF_GPIO_CFG, 16'h2000 | {3'h0, sc[i], 9'h000});
         repeat (3) @(posedge clk_i);
         check({oe_n, pin_o}, 2'h1);
      end
      $display("output mode done");
      wb(1'b1, `GPM_OFF_GPIO_CFG, cfg(4'hB, 2'h0));
      b = cnt[3];
      u_pin.low_pulse();
      repeat (8) @(posedge clk_i);
      check(cnt[3] - b, 0);
      do_reset();
      wb(1'b0, `GPM_OFF_GPIO_CFG, 16'h0000);
      check(rd, 32'h0000_0000);
      nvm_cfg <= cfg(4'hB, 2'h0);
      do_reset();
      b = cnt[3];
      u_pin.low_pulse();
      repeat (8) @(posedge clk_i);
      check(cnt[3] - b, 1);
      nvm_cfg <= cfg(4'h4, 2'h3);
      u_pin.set_level(1'b0);
      do_reset();
      check(vout, 2'h3);
      $display("reset and power-on done");
      final_report();
   end
endmodule
